// ===== common/dpsl_defs.svh
// constants for the debug port security lockout block
//
// Contract
// - the lock latch vote is high when at least 28 of its 32 stored bits equal the key pattern, else low.
// - while the sampled lock is high, debug and test entry is refused and all test, programming and debug ports stay off.
// - once the lock is high, no erase or change of the lock latch contents is accepted.
// - the lock latch output is sampled only at reset and that sample alone decides whether access is disabled.
// - locking needs the key loaded into the volatile copy, then programmed into the cells, then a reset.
// - after the key is written, port access keeps working until the next reset.
// - a key write is accepted only while no flash protection level is set, and ignored otherwise.
// - the lock latch contents can be read through the serial wire debug port.
// - the flash protection level may be lowered or cleared only by a full device erase.
// - either the JTAG or the SWD port can erase, program and verify the whole device.
// - a single flash block is erased, programmed or verified only when its security setting allows it.
// - the only debug plus trace pairings are SWD with single-wire trace, SWD with parallel trace, JTAG with parallel trace.
// - single-wire trace shares a JTAG pin, so it excludes JTAG.
// - parallel trace takes 5 pins, single-wire trace 1, JTAG 4 or 5, SWD 2.
// - every debug and trace port leaves reset disabled and only firmware enables it.
`ifndef DPSL_DEFS_SVH
`define DPSL_DEFS_SVH

// key pattern checked by the vote (value arbitrary)
`define DPSL_KEY_PATTERN 32'hA5C3_1E96
`define DPSL_KEY_W 32
`define DPSL_VOTE_MIN 6'h1C
// pin counts per port
`define DPSL_PINS_JTAG 4'h4
`define DPSL_PINS_JTAG_RST 4'h5
`define DPSL_PINS_SWD 4'h2
`define DPSL_PINS_SWV 4'h1
`define DPSL_PINS_TRACE 4'h5
`define DPSL_PINS_NONE 4'h0
// flash protection level meaning unprotected
`define DPSL_PROT_NONE 2'h0

`endif

// ===== common/dpsl_pkg.sv
// types for the debug port security lockout block
`default_nettype none
package dpsl_pkg;
  // host operations arriving over a debug port
  typedef enum logic [2:0] {
    OP_ERASE_ALL, OP_PROG_BLK, OP_ERASE_BLK, OP_VERIFY_BLK,
    OP_SET_PROT, OP_KEY_LOAD, OP_KEY_PROG, OP_KEY_READ
  } dpsl_op_t;
  typedef enum {ST_SAMPLE, ST_RUN} dpsl_st_t;
  typedef struct packed {
    logic valid;
    logic via_swd;
    dpsl_op_t op;
    logic [1:0] level;
    logic [31:0] data;
  } dpsl_req_t;
  typedef struct packed {
    logic valid;
    logic granted;
    logic [31:0] rdata;
  } dpsl_resp_t;
  typedef struct packed {
    logic jtag;
    logic ntrst;
    logic swd;
    logic swv;
    logic trace;
  } dpsl_ports_t;
  typedef struct packed {
    logic erase;
    logic prog;
    logic verify;
  } dpsl_perm_t;
  typedef struct packed {
    logic erase_all;
    logic erase_blk;
    logic prog_blk;
    logic verify_blk;
    logic set_prot;
    logic [1:0] level;
  } dpsl_flash_t;
  typedef struct packed {
    dpsl_st_t st;
    logic locked;
    dpsl_ports_t ports;
    logic [3:0] pins;
    logic cfg_err;
    logic [31:0] vol_key;
    logic nv_prog;
    dpsl_resp_t resp;
    dpsl_flash_t flash;
  } dpsl_state_t;
endpackage : dpsl_pkg
`default_nettype wire

// ===== src/dpsl_vote.sv
// super-majority vote of the stored latch bits against the key
`default_nettype none
`include "dpsl_defs.svh"
module dpsl_vote
  import dpsl_pkg::*;
#(
  parameter logic [31:0] KEY = `DPSL_KEY_PATTERN // value arbitrary
) (
  input wire logic [31:0] cells_i, // stored latch bits
  output logic hit_o // enough bits match
);
  logic [5:0] agree;
  // count agreeing bits
  always_comb begin
    agree = 6'h00;
    for (int i = 0; i < `DPSL_KEY_W; i++) begin
      agree = agree + {5'h00, ~(cells_i[i] ^ KEY[i])};
    end
  end
  assign hit_o = (agree >= `DPSL_VOTE_MIN);
endmodule : dpsl_vote
`default_nettype wire

// ===== src/dpsl_port_cfg.sv
// legality and pin count of a debug and trace port selection
`default_nettype none
`include "dpsl_defs.svh"
module dpsl_port_cfg
  import dpsl_pkg::*;
(
  input wire dpsl_ports_t req_i, // requested enables
  output logic legal_o, // selection allowed
  output logic [3:0] pins_o // pins taken
);
  // one debug port; single-wire trace shares a pin with jtag
  assign legal_o = !(req_i.jtag && req_i.swv)
                && !(req_i.jtag && req_i.swd)
                && !(req_i.ntrst && !req_i.jtag);
  // pin total of the selection
  always_comb begin
    pins_o = `DPSL_PINS_NONE;
    if (req_i.jtag) begin
      pins_o = req_i.ntrst ? `DPSL_PINS_JTAG_RST : `DPSL_PINS_JTAG;
    end
    if (req_i.swd) begin
      pins_o = pins_o + `DPSL_PINS_SWD;
    end
    if (req_i.swv) begin
      pins_o = pins_o + `DPSL_PINS_SWV;
    end
    if (req_i.trace) begin
      pins_o = pins_o + `DPSL_PINS_TRACE;
    end
  end
endmodule : dpsl_port_cfg
`default_nettype wire

// ===== src/dpsl_top.sv
// debug port security lockout: port selection, lock latch and host access gate
`default_nettype none
`include "dpsl_defs.svh"
module dpsl_top
  import dpsl_pkg::*;
(
  input wire logic clk_sys_i, // system clock, 125 MHz
  input wire logic reset_n_i, // async reset, active low
  // firmware port configuration
  input wire logic fw_cfg_wr_i, // firmware writes port selection
  input wire dpsl_ports_t fw_cfg_i, // requested port enables
  // host requests from the debug ports
  input wire dpsl_req_t req_i, // one-cycle request
  input wire dpsl_perm_t blk_perm_i, // addressed block security
  input wire logic [1:0] prot_level_i, // current flash protection
  // nonvolatile latch cells
  input wire logic [31:0] nv_cells_i, // stored latch bits
  // outputs
  output logic locked_o, // sampled lock decision
  output dpsl_ports_t ports_o, // live port enables
  output logic [3:0] pins_o, // pins taken by the ports
  output logic cfg_err_o, // last selection refused
  output dpsl_resp_t resp_o, // answer to the request
  output dpsl_flash_t flash_o, // flash command pulses
  output logic nv_prog_o, // program cells pulse
  output logic [31:0] nv_data_o // volatile copy to program
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  dpsl_state_t s_reg;
  dpsl_state_t s_next;
  logic vote_hit;
  logic cfg_legal;
  logic [3:0] cfg_pins;
  logic port_ok;
  logic blk_ok;
  logic key_ok;

  // vote over the stored cells
  dpsl_vote u_vote (
    .cells_i(nv_cells_i),
    .hit_o(vote_hit)
  );

  // check of the firmware selection
  dpsl_port_cfg u_cfg (
    .req_i(fw_cfg_i),
    .legal_o(cfg_legal),
    .pins_o(cfg_pins)
  );

  // ----------------------------------------------------------------
  // access qualifiers
  // ----------------------------------------------------------------

  // the request's own port must be live and the part unlocked
  always_comb begin
    port_ok = 1'b0;
    if (!s_reg.locked && s_reg.st == ST_RUN) begin
      if (req_i.via_swd) begin
        port_ok = s_reg.ports.swd;
      end else begin
        port_ok = s_reg.ports.jtag;
      end
    end
  end

  // per-block operation allowed by its security
  always_comb begin
    blk_ok = 1'b0;
    unique case (req_i.op)
      OP_ERASE_BLK: begin
        blk_ok = blk_perm_i.erase;
      end
      OP_PROG_BLK: begin
        blk_ok = blk_perm_i.prog;
      end
      OP_VERIFY_BLK: begin
        blk_ok = blk_perm_i.verify;
      end
      OP_ERASE_ALL, OP_SET_PROT, OP_KEY_LOAD, OP_KEY_PROG, OP_KEY_READ: begin
        blk_ok = 1'b0;
      end
    endcase
  end

  // key changes need no protection set and no lock
  assign key_ok = (prot_level_i == `DPSL_PROT_NONE) && !s_reg.locked;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  always_comb begin
    s_next = s_reg;
    s_next.resp = '0;
    s_next.flash = '0;
    s_next.nv_prog = 1'b0;
    unique case (s_reg.st)
      // first cycle after release: catch the lock decision once
      ST_SAMPLE: begin
        s_next.locked = vote_hit;
        s_next.st = ST_RUN;
      end
      ST_RUN: begin
        // firmware port selection; nothing opens while locked
        if (fw_cfg_wr_i && !s_reg.locked) begin
          if (cfg_legal) begin
            s_next.ports = fw_cfg_i;
            s_next.pins = cfg_pins;
            s_next.cfg_err = 1'b0;
          end else begin
            s_next.cfg_err = 1'b1;
          end
        end
        if (s_reg.locked) begin
          s_next.ports = '0;
          s_next.pins = `DPSL_PINS_NONE;
        end
        // host request: answered the next cycle
        if (req_i.valid) begin
          s_next.resp.valid = 1'b1;
          if (port_ok) begin
            unique case (req_i.op)
              OP_ERASE_ALL: begin
                s_next.resp.granted = 1'b1;
                s_next.flash.erase_all = 1'b1;
              end
              OP_ERASE_BLK: begin
                s_next.resp.granted = blk_ok;
                s_next.flash.erase_blk = blk_ok;
              end
              OP_PROG_BLK: begin
                s_next.resp.granted = blk_ok;
                s_next.flash.prog_blk = blk_ok;
              end
              OP_VERIFY_BLK: begin
                s_next.resp.granted = blk_ok;
                s_next.flash.verify_blk = blk_ok;
              end
              OP_SET_PROT: begin
                // raising is free, lowering only by full erase
                if (req_i.level >= prot_level_i) begin
                  s_next.resp.granted = 1'b1;
                  s_next.flash.set_prot = 1'b1;
                  s_next.flash.level = req_i.level;
                end
              end
              OP_KEY_LOAD: begin
                if (key_ok) begin
                  s_next.resp.granted = 1'b1;
                  s_next.vol_key = req_i.data;
                end
              end
              OP_KEY_PROG: begin
                if (key_ok) begin
                  s_next.resp.granted = 1'b1;
                  s_next.nv_prog = 1'b1;
                end
              end
              OP_KEY_READ: begin
                if (req_i.via_swd) begin
                  s_next.resp.granted = 1'b1;
                  s_next.resp.rdata = nv_cells_i;
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // all ports closed and lock assumed until sampled
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      s_reg.st <= ST_SAMPLE;
      s_reg.locked <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  assign locked_o = s_reg.locked;
  assign ports_o = s_reg.ports;
  assign pins_o = s_reg.pins;
  assign cfg_err_o = s_reg.cfg_err;
  assign resp_o = s_reg.resp;
  assign flash_o = s_reg.flash;
  assign nv_prog_o = s_reg.nv_prog;
  assign nv_data_o = s_reg.vol_key;

endmodule : dpsl_top
`default_nettype wire

// ===== verif/dpsl_checker.sv
// port assertions for the debug port security lockout block
`default_nettype none
`include "dpsl_defs.svh"
module dpsl_checker
  import dpsl_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire dpsl_req_t req_i, // host request
  input wire dpsl_perm_t blk_perm_i, // block security
  input wire logic [1:0] prot_level_i, // flash protection
  input wire logic [31:0] nv_cells_i, // latch cells
  input wire logic locked_o, // lock decision
  input wire dpsl_ports_t ports_o, // port enables
  input wire logic [3:0] pins_o, // pins taken
  input wire dpsl_resp_t resp_o, // answer
  input wire dpsl_flash_t flash_o, // flash pulses
  input wire logic nv_prog_o // program pulse
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // lock vote and its hold
  a_vote_at_reset: assert property (!$past(reset_n_i, 2) && $past(reset_n_i) |->
    locked_o == ($countones(~($past(nv_cells_i) ^ `DPSL_KEY_PATTERN)) >= 28)) else $error("lock vote wrong");
  a_lock_held: assert property ($past(reset_n_i, 2) && $past(reset_n_i) |-> $stable(locked_o))
    else $error("lock changed");
  a_ports_after_reset: assert property (!$past(reset_n_i) |-> ports_o == '0)
    else $error("ports on after reset");
  a_lock_ports_off: assert property (locked_o |-> ports_o == '0 && !nv_prog_o)
    else $error("port or latch live while locked");
  a_lock_refuses: assert property (locked_o && req_i.valid |=>
    resp_o.valid && !resp_o.granted && !flash_o.erase_all) else $error("request served while locked");
  // port selection
  a_pin_count: assert property (pins_o == 4'(ports_o.jtag * (4 + ports_o.ntrst) +
    2 * ports_o.swd + ports_o.swv + 5 * ports_o.trace)) else $error("pin count wrong");
  a_pair_legal: assert property (!(ports_o.jtag && (ports_o.swv || ports_o.swd)))
    else $error("illegal port pairing");
  // host request gating
  a_key_prot: assert property (req_i.valid && req_i.op inside {OP_KEY_LOAD, OP_KEY_PROG} &&
    prot_level_i != 2'h0 |=> !resp_o.granted && !nv_prog_o) else $error("key taken under protection");
  a_read_jtag: assert property (req_i.valid && req_i.op == OP_KEY_READ && !req_i.via_swd |=>
    !resp_o.granted) else $error("latch read over jtag");
  a_blk_perm: assert property (req_i.valid && req_i.op == OP_PROG_BLK && !blk_perm_i.prog |=>
    !resp_o.granted && !flash_o.prog_blk) else $error("block program without permission");
  a_prot_lower: assert property (req_i.valid && req_i.op == OP_SET_PROT &&
    req_i.level < prot_level_i |=> !flash_o.set_prot) else $error("protection lowered");
  c_locked: cover property (locked_o);
  c_prog: cover property (resp_o.granted && nv_prog_o);
  c_erase: cover property (flash_o.erase_all);
endmodule : dpsl_checker
`default_nettype wire

// ===== verif/dpsl_host.sv
// debug host model with the latch cells behind the block
`default_nettype none
module dpsl_host
  import dpsl_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic nv_prog_i, // program pulse
  input wire logic [31:0] nv_data_i, // volatile key copy
  input wire dpsl_resp_t resp_i, // answer
  output var dpsl_req_t req_o, // request
  output var logic [31:0] cells_o // nonvolatile cells
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_o = '0;
    cells_o = 32'h0000_0000;
  end
  // cells keep the copy across resets
  always @(posedge clk_sys_i) begin
    if (nv_prog_i) begin
      cells_o <= nv_data_i;
    end
  end
  // one request pulse, answer taken a cycle on
  task automatic send(input logic swd, input dpsl_op_t op, input logic [1:0] lvl, input logic [31:0] d,
                      output dpsl_resp_t r);
    @(negedge clk_sys_i);
    req_o = {1'b1, swd, op, lvl, d};
    @(negedge clk_sys_i);
    req_o.valid = 1'b0;
    req_o.data = ~d; // released data does not linger
    r = resp_i;
  endtask : send
endmodule : dpsl_host
`default_nettype wire

// ===== verif/dpsl_top_tb.sv
// self-checking bench of the debug port security lockout block
`default_nettype none
`include "dpsl_defs.svh"
module dpsl_top_tb import dpsl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, reset_n_i, fw_cfg_wr_i, locked_o, cfg_err_o, nv_prog_o;
  dpsl_ports_t fw_cfg_i, ports_o;
  dpsl_req_t req_i;
  dpsl_perm_t blk_perm_i;
  logic [1:0] prot_level_i;
  logic [31:0] nv_cells_i, nv_data_o;
  logic [3:0] pins_o;
  dpsl_resp_t resp_o, r;
  dpsl_flash_t flash_o;
  int mismatches, n_checks;
  localparam logic [31:0] KEY = `DPSL_KEY_PATTERN;
  dpsl_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fw_cfg_wr_i(fw_cfg_wr_i), .fw_cfg_i(fw_cfg_i),
    .req_i(req_i), .blk_perm_i(blk_perm_i), .prot_level_i(prot_level_i), .nv_cells_i(nv_cells_i),
    .locked_o(locked_o), .ports_o(ports_o), .pins_o(pins_o), .cfg_err_o(cfg_err_o), .resp_o(resp_o),
    .flash_o(flash_o), .nv_prog_o(nv_prog_o), .nv_data_o(nv_data_o));
  dpsl_host host (.clk_sys_i(clk_sys_i), .nv_prog_i(nv_prog_o), .nv_data_i(nv_data_o), .resp_i(resp_o),
    .req_o(req_i), .cells_o(nv_cells_i));
  // clock and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(8 * 1000);
    mismatches++;
    results;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // reset with given cells, vote lands on the first edge
  task automatic do_reset(input logic [31:0] cells, input logic lk);
    reset_n_i = 1'b0;
    @(negedge clk_sys_i);
    // cells loaded inside reset, clear of the model's own start-up value
    host.cells_o = cells;
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(locked_o, lk);
    chk(ports_o, 5'h00);
  endtask : do_reset
  task automatic cfg(input dpsl_ports_t c, input dpsl_ports_t ep, input logic [3:0] pn, input logic err);
    @(negedge clk_sys_i);
    fw_cfg_wr_i = 1'b1;
    fw_cfg_i = c;
    @(negedge clk_sys_i);
    fw_cfg_wr_i = 1'b0;
    chk({ports_o, pins_o, cfg_err_o}, {ep, pn, err});
  endtask : cfg
  task automatic req(input logic swd, input dpsl_op_t op, input logic [1:0] lv, input logic [31:0] d,
                     input logic g, input logic [31:0] rd);
    host.send(swd, op, lv, d, r);
    chk({r.valid, r.granted, r.rdata}, {1'b1, g, rd});
  endtask : req
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_vote;
    do_reset(KEY ^ 32'h0000_000F, 1'b1);
    do_reset(KEY ^ 32'h0000_001F, 1'b0);
  endtask : t_vote
  task automatic t_pairing;
    cfg(5'b00110, 5'b00110, 4'h3, 1'b0);
    cfg(5'b00101, 5'b00101, 4'h7, 1'b0);
    cfg(5'b11001, 5'b11001, 4'hA, 1'b0);
    cfg(5'b10010, 5'b11001, 4'hA, 1'b1);
    cfg(5'b10001, 5'b10001, 4'h9, 1'b0);
    req(1'b0, OP_ERASE_ALL, 2'h0, 32'h0, 1'b1, 32'h0);
    chk(flash_o.erase_all, 1'b1);
    req(1'b0, OP_KEY_READ, 2'h0, 32'h0, 1'b0, 32'h0);
  endtask : t_pairing
  task automatic t_access;
    cfg(5'b00101, 5'b00101, 4'h7, 1'b0);
    cfg(5'b10100, 5'b00101, 4'h7, 1'b1);
    blk_perm_i = 3'b100;
    req(1'b1, OP_ERASE_BLK, 2'h0, 32'h0, 1'b1, 32'h0);
    chk(flash_o.erase_blk, 1'b1);
    req(1'b1, OP_VERIFY_BLK, 2'h0, 32'h0, 1'b0, 32'h0);
    blk_perm_i = 3'b101;
    req(1'b1, OP_PROG_BLK, 2'h0, 32'h0, 1'b0, 32'h0);
    blk_perm_i = 3'b010;
    req(1'b1, OP_PROG_BLK, 2'h0, 32'h0, 1'b1, 32'h0);
    chk(flash_o.prog_blk, 1'b1);
    prot_level_i = 2'h2;
    req(1'b1, OP_SET_PROT, 2'h1, 32'h0, 1'b0, 32'h0);
    req(1'b1, OP_KEY_LOAD, 2'h0, KEY, 1'b0, 32'h0);
    req(1'b1, OP_SET_PROT, 2'h3, 32'h0, 1'b1, 32'h0);
    chk({flash_o.set_prot, flash_o.level}, {1'b1, 2'h3});
    prot_level_i = 2'h0;
  endtask : t_access
  task automatic t_lock;
    req(1'b1, OP_KEY_LOAD, 2'h0, KEY, 1'b1, 32'h0);
    chk(nv_data_o, KEY);
    req(1'b1, OP_KEY_PROG, 2'h0, 32'h0, 1'b1, 32'h0);
    chk(nv_prog_o, 1'b1);
    req(1'b1, OP_KEY_READ, 2'h0, 32'h0, 1'b1, KEY);
    chk(locked_o, 1'b0);
    do_reset(host.cells_o, 1'b1);
    cfg(5'b00101, 5'b00000, 4'h0, 1'b0);
    req(1'b1, OP_KEY_LOAD, 2'h0, 32'h0000_0001, 1'b0, 32'h0);
    chk(nv_data_o, 32'h0);
    req(1'b1, OP_ERASE_ALL, 2'h0, 32'h0, 1'b0, 32'h0);
  endtask : t_lock
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    fw_cfg_wr_i = 1'b0;
    fw_cfg_i = 5'h00;
    blk_perm_i = 3'b000;
    prot_level_i = 2'h0;
    t_vote;
    t_pairing;
    t_access;
    t_lock;
    results;
  end
endmodule : dpsl_top_tb
bind dpsl_top dpsl_checker chk_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i),
  .blk_perm_i(blk_perm_i), .prot_level_i(prot_level_i), .nv_cells_i(nv_cells_i), .locked_o(locked_o),
  .ports_o(ports_o), .pins_o(pins_o), .resp_o(resp_o), .flash_o(flash_o), .nv_prog_o(nv_prog_o));
`default_nettype wire
